/* File: inc/sbs_pkg.sv */
// Overview of operation
// [RULE1] High chip select sampled each edge, active high
// [RULE2] Low select b sampled; all three select
// [RULE3] Select a low; gates processor address strobe
// [RULE4] Output enable low drives data, unclocked; code synchronises it and registers the data enables
// [RULE5] Sleep high: standby, inputs ignored, array kept
// [RULE6] Sleep input pulled down: active by default
// [RULE7] Sleep entry and exit take two cycles
// [RULE8] Burst order high interleaved, low linear
// [RULE9] Burst order pulled up: interleaved by default
// [RULE10] Two-bit burst counter wraps in four
// [RULE11] Data 32 bits two-way, address 17 bits
// [RULE12] Input data captured on rising edge
// [RULE13] Read data from address of previous edge
// [RULE14] Write detected forces data outputs off
// [RULE15] Direction set by enable and write detect
// [RULE16] Deselected: no new access, no new drive; code keeps driving the data pins while deselected if output enable is low
//
// Purpose: Constants and types for the burst SRAM pin control.
// Assumes: One 200 MHz clock, synchronous active-high reset.
// Notes:   Memory depth is fixed at 128K words.
package sbs_pkg;
   localparam int              ADDR_W       = 17;
   localparam int              DATA_W       = 32;
   localparam int              BE_W         = 4;
   localparam int              FIFO_DEPTH   = 4;
   localparam int              CLK_PERIOD_NS = 5;
   localparam int              SLEEP_NS     = 10;
   localparam int              SLEEP_CYCLES = (SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]      SLEEP_CNT_INIT = 2'(SLEEP_CYCLES);
   localparam logic [1:0]      BEAT_RESET   = 2'h0;
   localparam logic            MODE_INTERLEAVED = 1'b1;
   typedef enum logic [1:0] {SBS_AWAKE, SBS_ENTERING, SBS_ASLEEP, SBS_LEAVING} sbs_sleep_type;
endpackage : sbs_pkg

/* File: hdl/sbs_fifo.sv */
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
module sbs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // Handshakes on each side
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_in_ready  = (count != (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign o_out_data  = store[rd_ptr];

   // Storage write
   always_ff @(posedge i_mclk) begin
      if (push) begin
         store[wr_ptr] <= i_in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop)  rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end
endmodule : sbs_fifo

/* File: hdl/sbs_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to i_mclk.
// Notes:   Output changes only when stages two and three agree.
`timescale 1ns/1ps
module sbs_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_level
);
   logic s1;
   logic s2;
   logic s3;

   // Chain and filter
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         s1      <= INIT;
         s2      <= INIT;
         s3      <= INIT;
         o_level <= INIT;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) o_level <= s3;
      end
   end
endmodule : sbs_sync

/* File: hdl/sbs_sram.sv */
// Purpose: Synchronous burst SRAM device: selects, strobes, burst, sleep, data pins.
// Assumes: Pins already resolved from enables; pull defaults applied by pad ring.
// Notes:   Read data passes a 4-word FIFO before the data pins.
`timescale 1ns/1ps
module sbs_sram
   import sbs_pkg::*;
(
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst,
   input  wire logic                        i_chip_select_low_a_n,
   input  wire logic                        i_chip_select_high,
   input  wire logic                        i_chip_select_low_b_n,
   input  wire logic                        i_processor_addr_strobe_n,
   input  wire logic                        i_controller_addr_strobe_n,
   input  wire logic                        i_advance_n,
   input  wire logic                        i_global_write_n,
   input  wire logic                        i_byte_write_en_n,
   input  wire logic [sbs_pkg::BE_W-1:0]    i_byte_sel_n,
   input  wire logic [sbs_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic                        i_out_enable_n,
   input  wire logic                        i_sleep_request,
   input  wire logic                        i_burst_mode,
   input  wire logic [sbs_pkg::DATA_W-1:0]  i_data,
   output logic      [sbs_pkg::DATA_W-1:0]  o_data,
   output logic      [sbs_pkg::DATA_W-1:0]  o_data_oe,
   output logic                             o_sleeping
);
   import sbs_pkg::*;

   // Burst address for a start value and beat
   function automatic logic [1:0] burst_addr(input logic [1:0] start, input logic [1:0] beat,
                                             input logic interleaved);
      burst_addr = interleaved ? (start ^ beat) : 2'(start + beat);  // [RULE10]
   endfunction : burst_addr

   logic [DATA_W-1:0] rd_word;
   logic              oe_n_sync;
   logic              sleep_sync;
   logic              mode_sync;
   sbs_sleep_type     sleep_state;
   logic [1:0]        sleep_cnt;
   logic              awake;
   logic              selected;
   logic              start_p;
   logic              start_c;
   logic              start_any;
   logic              write_req;
   logic [ADDR_W-1:0] base_addr;
   logic [1:0]        beat;
   logic [1:0]        next_beat;
   logic              burst_live;
   logic              pend_write;
   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] acc_addr;
   logic [ADDR_W-1:0] adv_addr;
   logic              do_read;
   logic              do_write;
   logic [BE_W-1:0]   lanes;
   logic              write_seen;
   logic              fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data;
   logic              drive;

   // Output enable and sleep arrive asynchronously
   sbs_sync #(.INIT(1'b1)) u_oe_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async (i_out_enable_n),
      .o_level (oe_n_sync)
   );
   sbs_sync #(.INIT(1'b0)) u_sleep_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async (i_sleep_request),  // [RULE6]
      .o_level (sleep_sync)
   );
   sbs_sync #(.INIT(MODE_INTERLEAVED)) u_mode_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async (i_burst_mode),  // [RULE9]
      .o_level (mode_sync)
   );

   // Sleep sequencing, two cycles each way
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sleep_state <= SBS_AWAKE;
         sleep_cnt   <= BEAT_RESET;
      end else begin
         case (sleep_state)
            SBS_AWAKE: begin
               if (sleep_sync) begin  // [RULE5]
                  sleep_state <= SBS_ENTERING;
                  sleep_cnt   <= SLEEP_CNT_INIT - 2'h1;
               end
            end
            SBS_ENTERING: begin
               if (sleep_cnt == 2'h0) sleep_state <= SBS_ASLEEP;  // [RULE7]
               else sleep_cnt <= sleep_cnt - 2'h1;
            end
            SBS_ASLEEP: begin
               if (!sleep_sync) begin
                  sleep_state <= SBS_LEAVING;
                  sleep_cnt   <= SLEEP_CNT_INIT - 2'h1;
               end
            end
            SBS_LEAVING: begin
               if (sleep_cnt == 2'h0) sleep_state <= SBS_AWAKE;  // [RULE7]
               else sleep_cnt <= sleep_cnt - 2'h1;
            end
            default: sleep_state <= SBS_AWAKE;
         endcase
      end
   end
   assign awake = (sleep_state == SBS_AWAKE);

   // Chip select and strobe decode; sleep ignores all inputs
   assign selected  = !i_chip_select_low_a_n && i_chip_select_high && !i_chip_select_low_b_n;  // [RULE1] [RULE2]
   assign start_p   = awake && !i_chip_select_low_a_n && !i_processor_addr_strobe_n && selected;  // [RULE3] [RULE16]
   assign start_c   = awake && selected && i_processor_addr_strobe_n && !i_controller_addr_strobe_n;  // [RULE16]
   assign start_any = start_p || start_c;
   assign write_req = !i_global_write_n || (!i_byte_write_en_n && (i_byte_sel_n != '1));
   assign lanes     = !i_global_write_n ? '1 : ~i_byte_sel_n;

   // Address register and burst counter
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         base_addr  <= '0;
         beat       <= BEAT_RESET;
         burst_live <= 1'b0;
      end else if (!awake) begin
         burst_live <= 1'b0;  // [RULE5]
      end else if (start_any) begin
         base_addr  <= i_addr;  // [RULE11]
         beat       <= BEAT_RESET;
         burst_live <= 1'b1;
      end else if (burst_live && !i_advance_n) begin
         beat <= next_beat;  // [RULE10]
      end
   end
   assign cur_addr = {base_addr[ADDR_W-1:2], burst_addr(base_addr[1:0], beat, mode_sync)};  // [RULE8]

   // Address that an advance moves to; the access at that edge uses it
   assign next_beat = beat + 2'h1;
   assign adv_addr  = {base_addr[ADDR_W-1:2], burst_addr(base_addr[1:0], next_beat, mode_sync)};  // [RULE10]

   // Processor-started cycle ignores write inputs in its first cycle
   always_ff @(posedge i_mclk) begin
      if (i_rst) pend_write <= 1'b0;
      else pend_write <= awake && start_p;
   end

   // Access decode: controller write at start, later writes in burst
   assign acc_addr = start_any ? i_addr : (!i_advance_n ? adv_addr : cur_addr);
   assign do_write = awake && write_req && !start_p && (start_c || burst_live || pend_write);
   assign do_read  = awake && !write_req && (start_any || (burst_live && !i_advance_n));

   // Memory array, one store per byte lane so each has a single writer; kept during sleep
   genvar gl;
   generate
      for (gl = 0; gl < BE_W; gl++) begin : g_lane
         logic [7:0] lane_mem [2**ADDR_W];
         always_ff @(posedge i_mclk) begin
            if (do_write && lanes[gl]) begin
               lane_mem[acc_addr] <= i_data[gl*8 +: 8];  // [RULE12]
            end
         end
         assign rd_word[gl*8 +: 8] = lane_mem[acc_addr];
      end
   endgenerate

   // Write detect holds outputs off for the cycle after a write
   always_ff @(posedge i_mclk) begin
      if (i_rst) write_seen <= 1'b0;
      else write_seen <= do_write || (awake && start_any && write_req);  // [RULE14]
   end

   // Read word queued with one edge of latency
   sbs_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_in_valid  (do_read),
      .o_in_ready  (),
      .i_in_data   (rd_word),  // [RULE13]
      .o_out_valid (fifo_out_valid),
      .i_out_ready (1'b1),
      .o_out_data  (fifo_out_data)
   );

   // Drive decision from enable and write detect
   assign drive = !oe_n_sync && !write_seen && !do_write && awake;  // [RULE4] [RULE15]

   // Registered data pins and enables
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_data     <= '0;
         o_data_oe  <= '0;
         o_sleeping <= 1'b0;
      end else begin
         if (fifo_out_valid) o_data <= fifo_out_data;  // [RULE13]
         o_data_oe  <= drive ? '1 : '0;  // [RULE14]
         o_sleeping <= !awake;
      end
   end
endmodule : sbs_sram

/* File: dv/sbs_sram_monitor.sv */
// Purpose: Port checks for the burst SRAM pin control.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every device instance.
`timescale 1ns/1ps
module sbs_sram_monitor
   import sbs_pkg::*;
(
   input wire logic                       i_mclk,
   input wire logic                       i_rst,
   input wire logic                       i_chip_select_low_a_n,
   input wire logic                       i_chip_select_high,
   input wire logic                       i_chip_select_low_b_n,
   input wire logic                       i_processor_addr_strobe_n,
   input wire logic                       i_controller_addr_strobe_n,
   input wire logic                       i_advance_n,
   input wire logic                       i_global_write_n,
   input wire logic                       i_byte_write_en_n,
   input wire logic                       i_out_enable_n,
   input wire logic                       i_sleep_request,
   input wire logic [sbs_pkg::DATA_W-1:0] o_data,
   input wire logic [sbs_pkg::DATA_W-1:0] o_data_oe,
   input wire logic                       o_sleeping
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic sel;
   logic go;
   // All three selects active, and any start or advance
   assign sel = !i_chip_select_low_a_n && i_chip_select_high && !i_chip_select_low_b_n;
   assign go  = (sel && !(i_processor_addr_strobe_n && i_controller_addr_strobe_n)) || !i_advance_n;
   write_off_a: assert property (sel && !i_controller_addr_strobe_n && i_processor_addr_strobe_n
      && !i_global_write_n && !o_sleeping |=> o_data_oe == '0) else $error("data driven after write");
   oe_off_a: assert property (i_out_enable_n [*7] |-> o_data_oe == '0)
      else $error("data driven with enable high");
   oe_on_a: assert property ((!i_out_enable_n && i_global_write_n && i_byte_write_en_n
      && !o_sleeping) [*7] |-> o_data_oe == '1) else $error("data not driven");
   oe_whole_a: assert property (o_data_oe == '0 || o_data_oe == '1)
      else $error("split drive");
   sleep_in_a: assert property (i_sleep_request [*8] |-> o_sleeping)
      else $error("no sleep");
   sleep_out_a: assert property (!i_sleep_request [*8] |=> !o_sleeping)
      else $error("still asleep");
   sleep_hold_a: assert property (o_sleeping |=> $stable(o_data))
      else $error("data moved asleep");
   idle_hold_a: assert property (!go ##1 !go |=> $stable(o_data))
      else $error("data moved unselected");
   reset_quiet_a: assert property (disable iff (1'b0) i_rst |=> o_data_oe == '0 && !o_sleeping)
      else $error("busy after reset");
   cover property (sel && !i_processor_addr_strobe_n);
   cover property (!i_advance_n [*3]);
   cover property (o_sleeping);
endmodule : sbs_sram_monitor

bind sbs_sram sbs_sram_monitor i_mon (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_chip_select_low_a_n(i_chip_select_low_a_n), .i_chip_select_high(i_chip_select_high),
   .i_chip_select_low_b_n(i_chip_select_low_b_n), .i_processor_addr_strobe_n(i_processor_addr_strobe_n),
   .i_controller_addr_strobe_n(i_controller_addr_strobe_n), .i_advance_n(i_advance_n),
   .i_global_write_n(i_global_write_n), .i_byte_write_en_n(i_byte_write_en_n),
   .i_out_enable_n(i_out_enable_n), .i_sleep_request(i_sleep_request), .o_data(o_data),
   .o_data_oe(o_data_oe), .o_sleeping(o_sleeping));

/* File: dv/sbs_host_model.sv */
// Purpose: Processor-side model driving the burst SRAM pins.
// Assumes: Control pins change at falling edges; a released data bus flips at rising edges.
// Notes:   A released data bus shows the inverse of its last value.
`timescale 1ns/1ps
module sbs_host_model
   import sbs_pkg::*;
(
   input  wire logic                       i_mclk,
   input  wire logic [sbs_pkg::DATA_W-1:0] i_q,
   input  wire logic [sbs_pkg::DATA_W-1:0] i_q_oe,
   input  wire logic                       i_sleeping,
   output logic                            o_sel_a_n,
   output logic                            o_sel_h,
   output logic                            o_sel_b_n,
   output logic                            o_pstb_n,
   output logic                            o_cstb_n,
   output logic                            o_adv_n,
   output logic                            o_gw_n,
   output logic      [sbs_pkg::ADDR_W-1:0] o_addr,
   output logic      [sbs_pkg::DATA_W-1:0] o_bus,
   output logic                            o_oe_n,
   output logic                            o_sleep,
   output logic                            o_mode
);
   logic [DATA_W-1:0] last;
   logic [DATA_W-1:0] wdat;
   logic              host_en;
   logic              stuck;
   logic [DATA_W-1:0] rq[$];
   // Pin levels: mask bit set means that select is active
   task automatic pins(input logic [2:0] m, input logic p, input logic c, input logic a, input logic g);
      o_sel_a_n = ~m[0];
      o_sel_h = m[1];
      o_sel_b_n = ~m[2];
      o_pstb_n = p;
      o_cstb_n = c;
      o_adv_n = a;
      o_gw_n = g;
   endtask : pins
   // Idle start: deselected, sleep low, interleaved order
   initial begin
      pins(3'h0, 1'b1, 1'b1, 1'b1, 1'b1);
      o_addr = '0;
      o_oe_n = 1'b0;
      o_sleep = 1'b0;
      o_mode = 1'b1;
      host_en = 1'b0;
      wdat = '0;
      stuck = 1'b0;
   end
   // Bus resolution: device drive, host drive, or flipped last value
   always_ff @(posedge i_mclk) begin
      last <= o_bus;
   end
   assign o_bus = (i_q & i_q_oe) | ((host_en ? wdat : ~last) & ~i_q_oe);
   // Controller-strobe global write of one word
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(negedge i_mclk);
      o_oe_n = 1'b1;
      n = 0;
      while (i_q_oe !== '0 && n < 20) begin
         @(negedge i_mclk);
         n++;
      end
      if (n == 20) stuck = 1'b1;
      o_addr = a;
      wdat = d;
      host_en = 1'b1;
      pins(3'h7, 1'b1, 1'b0, 1'b1, 1'b0);
      @(negedge i_mclk);
      host_en = 1'b0;
      pins(3'h0, 1'b1, 1'b1, 1'b1, 1'b1);
   endtask : wr
   // Processor-strobe read of n beats; beats queued as they appear
   task automatic rd(input logic [ADDR_W-1:0] a, input int n, input logic [2:0] m);
      @(negedge i_mclk);
      o_oe_n = 1'b0;
      o_addr = a;
      pins(m, 1'b0, 1'b1, 1'b1, 1'b1);
      for (int j = 1; j < n + 3; j++) begin
         @(negedge i_mclk);
         pins((j < n) ? m : 3'h0, 1'b1, 1'b1, !(j < n), 1'b1);
         if (j >= 2 && j < n + 2) rq.push_back(i_q);
      end
   endtask : rd
   // Sleep while deselected, then hold selects off for recovery
   task automatic nap(input int n, output logic s);
      @(negedge i_mclk);
      o_sleep = 1'b1;
      repeat (n) @(negedge i_mclk);
      s = i_sleeping;
      o_sleep = 1'b0;
      repeat (n) @(negedge i_mclk);
   endtask : nap
   // Order and output enable, then settle through synchronisers
   task automatic hold(input logic m, input logic e);
      @(negedge i_mclk);
      o_mode = m;
      o_oe_n = e;
      repeat (8) @(negedge i_mclk);
   endtask : hold
endmodule : sbs_host_model

/* File: dv/sbs_sram_tb.sv */
// Purpose: Self-checking bench for the burst SRAM pin control.
// Assumes: 200 MHz clock, reset held 16 cycles.
// Notes:   Byte write inputs held off; global writes only.
`timescale 1ns/1ps
module sbs_sram_tb;
   import sbs_pkg::*;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
   logic              mclk, rst, cs_a_n, cs_h, cs_b_n, pstb_n, cstb_n, adv_n, gw_n, oe_n, sleep, mode, sleeping;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] bus, q, q_oe, v;
   int                err_total, compares;
   sbs_sram i_dut (.i_mclk(mclk), .i_rst(rst), .i_chip_select_low_a_n(cs_a_n), .i_chip_select_high(cs_h),
      .i_chip_select_low_b_n(cs_b_n), .i_processor_addr_strobe_n(pstb_n), .i_controller_addr_strobe_n(cstb_n),
      .i_advance_n(adv_n), .i_global_write_n(gw_n), .i_byte_write_en_n(1'b1), .i_byte_sel_n(4'hF),
      .i_addr(addr), .i_out_enable_n(oe_n), .i_sleep_request(sleep), .i_burst_mode(mode), .i_data(bus),
      .o_data(q), .o_data_oe(q_oe), .o_sleeping(sleeping));
   sbs_host_model i_host (.i_mclk(mclk), .i_q(q), .i_q_oe(q_oe), .i_sleeping(sleeping), .o_sel_a_n(cs_a_n),
      .o_sel_h(cs_h), .o_sel_b_n(cs_b_n), .o_pstb_n(pstb_n), .o_cstb_n(cstb_n), .o_adv_n(adv_n),
      .o_gw_n(gw_n), .o_addr(addr), .o_bus(bus), .o_oe_n(oe_n), .o_sleep(sleep), .o_mode(mode));
   always #2.5 mclk = ~mclk;
   function automatic logic [DATA_W-1:0] dat(input int k);
      return 32'h5A00_3C00 + 32'(k);
   endfunction : dat
   // Four writes, then each word read back
   task automatic t_rw;
      for (int k = 0; k < 4; k++) i_host.wr(17'h00104 + 17'(k), dat(k));
      for (int k = 0; k < 4; k++) begin
         i_host.rd(17'h00104 + 17'(k), 1, 3'h7);
         v = i_host.rq.pop_front();
         `CHK(v, dat(k))
      end
      `CHK(i_host.stuck, 1'b0)
      $display("t_rw done");
   endtask : t_rw
   // Four-beat bursts from start 1 in both orders
   task automatic t_burst;
      for (int m = 0; m < 2; m++) begin
         i_host.hold(1'(m), 1'b0);
         i_host.rd(17'h00105, 4, 3'h7);
         for (int k = 0; k < 4; k++) begin
            v = i_host.rq.pop_front();
            `CHK(v, dat(m ? (1 ^ k) : ((1 + k) % 4)))
         end
      end
      $display("t_burst done");
   endtask : t_burst
   // One select inactive in turn: read ignored, data unchanged
   task automatic t_desel;
      for (int s = 0; s < 3; s++) begin
         i_host.rd(17'h00104, 1, 3'h7);
         i_host.rd(17'h00106, 1, 3'h7 ^ 3'(1 << s));
         v = i_host.rq.pop_front();
         `CHK(v, dat(0))
         v = i_host.rq.pop_front();
         `CHK(v, dat(0))
      end
      $display("t_desel done");
   endtask : t_desel
   // Sleep and wake, array contents kept
   task automatic t_sleep;
      logic s;
      i_host.nap(12, s);
      `CHK(s, 1'b1)
      `CHK(sleeping, 1'b0)
      i_host.rd(17'h00107, 1, 3'h7);
      v = i_host.rq.pop_front();
      `CHK(v, dat(3))
      $display("t_sleep done");
   endtask : t_sleep
   // Output enable turns the whole bus off and on
   task automatic t_oe;
      i_host.hold(1'b1, 1'b1);
      `CHK(q_oe, 32'h0000_0000)
      i_host.hold(1'b1, 1'b0);
      `CHK(q_oe, 32'hFFFF_FFFF)
      $display("t_oe done");
   endtask : t_oe
   task automatic tally_and_finish;
      $display("compares=%0d mismatches=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // Reset, scenarios, verdict
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      err_total = 0;
      compares = 0;
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      `CHK(sleeping, 1'b0)
      t_rw();
      t_burst();
      t_desel();
      t_sleep();
      t_oe();
      tally_and_finish();
   end
endmodule : sbs_sram_tb
